// ---- shared/uds_pkg.sv ----
package uds_pkg;

    // Clock rate and the line-state times, with the cycle counts derived from them.
    localparam int CLK_MHZ          = 100;
    localparam int RESUME_NS        = 2500;
    localparam int RESUME_CYCLES    = (RESUME_NS * CLK_MHZ + 999) / 1000;
    localparam int BUS_RESET_NS     = 2500;
    localparam int BUS_RESET_CYCLES = (BUS_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int IDLE_US          = 3000;
    localparam int IDLE_CYCLES      = IDLE_US * CLK_MHZ;

    // Register byte offsets within the slave window.
    localparam logic [7:0] OFS_FLAGS      = 8'h00;
    localparam logic [7:0] OFS_DESC_BASE  = 8'h04;
    localparam logic [7:0] OFS_PWM_CTRL   = 8'h08;
    localparam logic [7:0] OFS_ERR_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_XFER_STAT  = 8'h10;
    localparam logic [7:0] OFS_PWM_TIMING = 8'h14;

    // Interrupt flag positions.
    localparam int FLAG_STALL  = 7;
    localparam int FLAG_RESUME = 5;
    localparam int FLAG_IDLE   = 4;
    localparam int FLAG_TOKEN  = 3;
    localparam int FLAG_SOF    = 2;
    localparam int FLAG_ERROR  = 1;
    localparam int FLAG_RESET  = 0;
    localparam logic [7:0] FLAG_W1C_MASK = 8'hBD;

    // VBUS PWM control fields and timing fields.
    localparam int PWM_EN_BIT     = 15;
    localparam int PWM_POL_BIT    = 9;
    localparam int PWM_CNT_BIT    = 8;
    localparam int PWM_PERIOD_LSB = 0;
    localparam int PWM_DUTY_LSB   = 8;

    // Reset values.
    localparam logic [7:0]  FLAGS_RST      = 8'h00;
    localparam logic [7:0]  DESC_BASE_RST  = 8'h00;
    localparam logic [7:0]  ERR_ENABLE_RST = 8'h00;
    localparam logic [15:0] PWM_TIMING_RST = 16'h0000;

    typedef struct packed {
        logic       stallSent;
        logic       sofReceived;
        logic       tokenDone;
        logic [7:0] tokenStatus;
        logic [7:0] errorStatus;
    } uds_link_evt_t;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b11
    } uds_bus_state_t;

endpackage

// ---- hdl/uds_stat_mem.sv ----
`timescale 1ns/1ps
module uds_stat_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic      [WIDTH-1:0]         rdData_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("uds_stat_mem: bad WIDTH or DEPTH");
        end
    end

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Write-first bypass so a word pushed into the head slot is seen at once.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= '0;
        end else if (wrEn && wrAddr == rdAddr) begin
            rdData_q <= wrData;
        end else begin
            rdData_q <= mem[rdAddr];
        end
    end

endmodule

// ---- hdl/uds_status_top.sv ----
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Sending a STALL handshake sets the stall-sent flag in bit 7 of the interrupt flags.
// - A K-state held on the data lines for 2.5 us sets the resume flag.
// - K-state is differential one at low speed and differential zero at full speed.
// - An unbroken Idle state of 3 ms or more sets the idle flag.
// - Finishing a token sets the token-complete flag and shows that token's status word.
// - Clearing the token-complete flag advances the status FIFO to the next completed token.
// - Receiving a Start-of-Frame token sets the start-of-frame flag.
// - The read-only error summary is set only while an enabled error is present.
// - A bus reset held 2.5 us sets the bus-reset flag once, not again until the reset ends.
// - Hardware sets the flags and a write of one clears the flags written with one, except read-only bit 1 and bit 3, which pops the status FIFO.
// - Bits 15 to 8 and bit 6 of the flag register read zero and ignore writes.
// - An 8-bit writable field resetting to zero gives address bits 31 to 24; other bits read zero.
// - With the PWM enable bit 15 low the output rests at the level set by polarity.
// - Polarity bit 9 high makes the output active-low resting high, low makes it active-high resting low.
// - The PWM counter runs only while counter enable bit 8 is one.
module uds_status_top #(
    parameter int IDLE_CYCLES = uds_pkg::IDLE_CYCLES,
    parameter int FIFO_DEPTH  = 4
) (
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic      [31:0]            hrdata,
    input  wire uds_pkg::uds_link_evt_t linkEvt,
    input  wire logic                   lowSpeed,
    input  wire logic                   dPlusPin,
    input  wire logic                   dMinusPin,
    output logic                        vbusPwm
);

    localparam int CW = $clog2(FIFO_DEPTH);
    localparam logic [19:0] RESUME_LIM = 20'(uds_pkg::RESUME_CYCLES);
    localparam logic [19:0] RESET_LIM  = 20'(uds_pkg::BUS_RESET_CYCLES);
    localparam logic [19:0] IDLE_LIM   = 20'(IDLE_CYCLES);

    initial begin
        if (IDLE_CYCLES < 2 || IDLE_CYCLES > 1048575) begin
            $error("uds_status_top: IDLE_CYCLES out of range");
        end
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
            $error("uds_status_top: FIFO_DEPTH must be a power of two");
        end
    end

    function automatic logic [19:0] satCount(input logic [19:0] cnt, input logic cond, input logic [19:0] lim);
        if (!cond) begin
            satCount = '0;
        end else if (cnt == lim) begin
            satCount = cnt;
        end else begin
            satCount = cnt + 20'h0_0001;
        end
    endfunction

    function automatic logic reached(input logic [19:0] cnt, input logic cond, input logic [19:0] lim);
        reached = cond && (cnt == lim - 20'h0_0001);
    endfunction

    uds_pkg::uds_bus_state_t busState_q;
    logic [7:0]      addr_q;
    logic            hreadyout_q;
    logic [31:0]     hrdata_q;
    logic            dPlusMeta_q;
    logic            dPlus_q;
    logic            dMinusMeta_q;
    logic            dMinus_q;
    logic [19:0]     kCnt_q;
    logic [19:0]     idleCnt_q;
    logic [19:0]     se0Cnt_q;
    logic [7:0]      stickyFlags_q;
    logic [7:0]      stickyFlags_d;
    logic            errFlag_q;
    logic            tokenFlag_q;
    logic [CW:0]     count_q;
    logic [CW:0]     count_d;
    logic [CW-1:0]   head_q;
    logic [CW-1:0]   head_d;
    logic [CW-1:0]   tail_q;
    logic [7:0]      statData;
    logic [7:0]      descBase_q;
    logic [7:0]      errEnable_q;
    logic            vbus_pwm_enable_q;
    logic            vbus_pwm_polarity_q;
    logic            pwmCntEn_q;
    logic [15:0]     pwmTiming_q;
    logic [7:0]      pwmCnt_q;
    logic            vbusPwm_q;
    logic            take;
    logic            wrPhase;
    logic            kState;
    logic            idleState;
    logic            se0State;
    logic            push;
    logic            pop;
    logic [7:0]      setVec;
    logic [7:0]      clrVec;
    logic [7:0]      flagsView;
    logic [31:0]     readMux;

    assign take    = hsel && htrans[1] && hready;
    assign wrPhase = (busState_q == uds_pkg::BUS_WRITE);

    // Bus phase tracking; reads take one wait state so they always see the last write.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busState_q <= uds_pkg::BUS_IDLE;
            addr_q     <= 8'h00;
        end else begin
            if (take) begin
                addr_q <= haddr[7:0];
            end
            unique case (busState_q)
                uds_pkg::BUS_IDLE, uds_pkg::BUS_WRITE: begin
                    busState_q <= !take ? uds_pkg::BUS_IDLE : (hwrite ? uds_pkg::BUS_WRITE : uds_pkg::BUS_READ);
                end
                uds_pkg::BUS_READ: begin
                    busState_q <= uds_pkg::BUS_IDLE;
                end
                default: begin
                    busState_q <= uds_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0000_0000;
        end else begin
            hreadyout_q <= !(take && !hwrite);
            if (busState_q == uds_pkg::BUS_READ) begin
                hrdata_q <= readMux;
            end
        end
    end

    always_comb begin
        flagsView = stickyFlags_q;
        flagsView[6] = 1'b0;
        flagsView[uds_pkg::FLAG_TOKEN] = tokenFlag_q;
        flagsView[uds_pkg::FLAG_ERROR] = errFlag_q;
        readMux = 32'h0000_0000;
        unique case (addr_q)
            uds_pkg::OFS_FLAGS:      readMux = {24'h00_0000, flagsView};
            uds_pkg::OFS_DESC_BASE:  readMux = {24'h00_0000, descBase_q};
            uds_pkg::OFS_PWM_CTRL:   readMux = {16'h0000, vbus_pwm_enable_q, 5'h00, vbus_pwm_polarity_q, pwmCntEn_q, 8'h00};
            uds_pkg::OFS_ERR_ENABLE: readMux = {24'h00_0000, errEnable_q};
            uds_pkg::OFS_XFER_STAT:  readMux = {24'h00_0000, (count_q != '0) ? statData : 8'h00};
            uds_pkg::OFS_PWM_TIMING: readMux = {16'h0000, pwmTiming_q};
            default:                 readMux = 32'h0000_0000;
        endcase
    end

    // Data lines come from pins, so both pass a two-stage synchroniser first.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dPlusMeta_q  <= 1'b0;
            dPlus_q      <= 1'b0;
            dMinusMeta_q <= 1'b0;
            dMinus_q     <= 1'b0;
        end else begin
            dPlusMeta_q  <= dPlusPin;
            dPlus_q      <= dPlusMeta_q;
            dMinusMeta_q <= dMinusPin;
            dMinus_q     <= dMinusMeta_q;
        end
    end

    assign kState    = lowSpeed ? (dPlus_q && !dMinus_q) : (!dPlus_q && dMinus_q);
    assign idleState = lowSpeed ? (!dPlus_q && dMinus_q) : (dPlus_q && !dMinus_q);
    assign se0State  = !dPlus_q && !dMinus_q;

    // Counters saturate, so each line condition raises its flag once per episode.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kCnt_q    <= '0;
            idleCnt_q <= '0;
            se0Cnt_q  <= '0;
        end else begin
            kCnt_q    <= satCount(kCnt_q, kState, RESUME_LIM);
            idleCnt_q <= satCount(idleCnt_q, idleState, IDLE_LIM);
            se0Cnt_q  <= satCount(se0Cnt_q, se0State, RESET_LIM);
        end
    end

    always_comb begin
        setVec = 8'h00;
        setVec[uds_pkg::FLAG_STALL]  = linkEvt.stallSent;
        setVec[uds_pkg::FLAG_RESUME] = reached(kCnt_q, kState, RESUME_LIM);
        setVec[uds_pkg::FLAG_IDLE]   = reached(idleCnt_q, idleState, IDLE_LIM);
        setVec[uds_pkg::FLAG_SOF]    = linkEvt.sofReceived;
        setVec[uds_pkg::FLAG_RESET]  = reached(se0Cnt_q, se0State, RESET_LIM);
        clrVec = (wrPhase && addr_q == uds_pkg::OFS_FLAGS) ? (hwdata[7:0] & uds_pkg::FLAG_W1C_MASK) : 8'h00;
        stickyFlags_d = (stickyFlags_q & ~clrVec) | setVec;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stickyFlags_q <= uds_pkg::FLAGS_RST;
            errFlag_q     <= 1'b0;
        end else begin
            stickyFlags_q <= stickyFlags_d & uds_pkg::FLAG_W1C_MASK & ~(8'h01 << uds_pkg::FLAG_TOKEN);
            errFlag_q     <= |(linkEvt.errorStatus & errEnable_q);
        end
    end

    // A token finished while the FIFO is full is dropped; software must keep up.
    assign push = linkEvt.tokenDone && (count_q != (CW+1)'(FIFO_DEPTH));
    assign pop  = clrVec[uds_pkg::FLAG_TOKEN] && (count_q != '0);
    assign count_d = count_q + (CW+1)'(push) - (CW+1)'(pop);
    assign head_d  = pop ? head_q + CW'(1) : head_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_q     <= '0;
            head_q      <= '0;
            tail_q      <= '0;
            tokenFlag_q <= 1'b0;
        end else begin
            count_q     <= count_d;
            head_q      <= head_d;
            tail_q      <= push ? tail_q + CW'(1) : tail_q;
            tokenFlag_q <= (count_d != '0);
        end
    end

    uds_stat_mem #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_stat_mem (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .wrEn     (push),
        .wrAddr   (tail_q),
        .wrData   (linkEvt.tokenStatus),
        .rdAddr   (head_d),
        .rdData_q (statData)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            descBase_q  <= uds_pkg::DESC_BASE_RST;
            errEnable_q <= uds_pkg::ERR_ENABLE_RST;
            vbus_pwm_enable_q     <= 1'b0;
            vbus_pwm_polarity_q    <= 1'b0;
            pwmCntEn_q  <= 1'b0;
            pwmTiming_q <= uds_pkg::PWM_TIMING_RST;
        end else if (wrPhase) begin
            if (addr_q == uds_pkg::OFS_DESC_BASE) begin
                descBase_q <= hwdata[7:0];
            end
            if (addr_q == uds_pkg::OFS_ERR_ENABLE) begin
                errEnable_q <= hwdata[7:0];
            end
            if (addr_q == uds_pkg::OFS_PWM_CTRL) begin
                vbus_pwm_enable_q    <= hwdata[uds_pkg::PWM_EN_BIT];
                vbus_pwm_polarity_q   <= hwdata[uds_pkg::PWM_POL_BIT];
                pwmCntEn_q <= hwdata[uds_pkg::PWM_CNT_BIT];
            end
            if (addr_q == uds_pkg::OFS_PWM_TIMING) begin
                pwmTiming_q <= hwdata[15:0];
            end
        end
    end

    // Counter wraps at the period value; the output is active while below duty.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pwmCnt_q <= 8'h00;
        end else if (pwmCntEn_q) begin
            pwmCnt_q <= (pwmCnt_q >= pwmTiming_q[uds_pkg::PWM_PERIOD_LSB +: 8]) ? 8'h00 : pwmCnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vbusPwm_q <= 1'b0;
        end else if (!vbus_pwm_enable_q) begin
            vbusPwm_q <= vbus_pwm_polarity_q;
        end else begin
            vbusPwm_q <= (pwmCnt_q < pwmTiming_q[uds_pkg::PWM_DUTY_LSB +: 8]) ^ vbus_pwm_polarity_q;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign vbusPwm   = vbusPwm_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_take_read(logic [7:0] ofs);
        take && !hwrite && haddr[7:0] == ofs ##1 !hreadyout_q;
    endsequence

    property p_stall_set;
        linkEvt.stallSent |=> stickyFlags_q[uds_pkg::FLAG_STALL];
    endproperty
    a_stall_set: assert property (p_stall_set) else $error("stall flag not set");

    property p_resume_time;
        kState && kCnt_q == RESUME_LIM - 20'h0_0001 |=> stickyFlags_q[uds_pkg::FLAG_RESUME];
    endproperty
    a_resume_time: assert property (p_resume_time) else $error("resume flag late");

    property p_kstate_map;
        !kState ##1 kState |-> lowSpeed ? (dPlus_q && !dMinus_q) : (dMinus_q && !dPlus_q);
    endproperty
    a_kstate_map: assert property (p_kstate_map) else $error("wrong K mapping");

    property p_idle_early;
        !stickyFlags_q[uds_pkg::FLAG_IDLE] && idleCnt_q < IDLE_LIM - 20'h0_0001 |=> !stickyFlags_q[uds_pkg::FLAG_IDLE];
    endproperty
    a_idle_early: assert property (p_idle_early) else $error("idle flag too early");

    property p_token_set;
        linkEvt.tokenDone && count_q == '0 |=> tokenFlag_q && count_q == (CW+1)'(1);
    endproperty
    a_token_set: assert property (p_token_set) else $error("token flag not set");

    property p_token_pop;
        pop && !push |=> count_q == $past(count_q) - (CW+1)'(1) && head_q == $past(head_q) + CW'(1);
    endproperty
    a_token_pop: assert property (p_token_pop) else $error("status FIFO did not advance");

    property p_sof_set;
        linkEvt.sofReceived |=> stickyFlags_q[uds_pkg::FLAG_SOF];
    endproperty
    a_sof_set: assert property (p_sof_set) else $error("sof flag not set");

    property p_err_summary;
        ##1 errFlag_q == $past(|(linkEvt.errorStatus & errEnable_q));
    endproperty
    a_err_summary: assert property (p_err_summary) else $error("error summary mismatch");

    property p_reset_once;
        se0State && se0Cnt_q == RESET_LIM |-> !setVec[uds_pkg::FLAG_RESET];
    endproperty
    a_reset_once: assert property (p_reset_once) else $error("reset flag raised twice");

    property p_w1c_keep;
        wrPhase && addr_q == uds_pkg::OFS_FLAGS && !hwdata[uds_pkg::FLAG_STALL] && stickyFlags_q[uds_pkg::FLAG_STALL]
            |=> stickyFlags_q[uds_pkg::FLAG_STALL];
    endproperty
    a_w1c_keep: assert property (p_w1c_keep) else $error("flag lost on zero write");

    property p_w1c_clear;
        wrPhase && addr_q == uds_pkg::OFS_FLAGS && hwdata[uds_pkg::FLAG_SOF] && !linkEvt.sofReceived
            |=> !stickyFlags_q[uds_pkg::FLAG_SOF];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by one");

    property p_flags_read;
        s_take_read(uds_pkg::OFS_FLAGS) |=> hreadyout_q && hrdata_q[31:8] == 24'h00_0000 && !hrdata_q[6];
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("reserved flag bits not zero");

    property p_desc_read;
        s_take_read(uds_pkg::OFS_DESC_BASE) |=> hrdata_q == {24'h00_0000, descBase_q};
    endproperty
    a_desc_read: assert property (p_desc_read) else $error("descriptor base readback wrong");

    property p_pwm_rest;
        !vbus_pwm_enable_q ##1 !vbus_pwm_enable_q && $stable(vbus_pwm_polarity_q) |-> vbusPwm_q == vbus_pwm_polarity_q;
    endproperty
    a_pwm_rest: assert property (p_pwm_rest) else $error("pwm not at rest level");

    property p_pwm_polarity;
        vbus_pwm_enable_q && pwmCnt_q < pwmTiming_q[15:8] |=> vbusPwm_q == !$past(vbus_pwm_polarity_q);
    endproperty
    a_pwm_polarity: assert property (p_pwm_polarity) else $error("pwm active level wrong");

    property p_cnt_stop;
        !pwmCntEn_q |=> pwmCnt_q == $past(pwmCnt_q);
    endproperty
    a_cnt_stop: assert property (p_cnt_stop) else $error("pwm counter moved while stopped");

endmodule

// ---- bench/uds_host_model.sv ----
`timescale 1ns/1ps
module uds_host_model (
    input  wire logic              mclk,
    output uds_pkg::uds_link_evt_t linkEvt,
    output logic                   lowSpeed,
    output logic                   dPlusPin,
    output logic                   dMinusPin
);
    // The host starts in full speed with the line parked in J.
    initial begin
        linkEvt   = '0;
        lowSpeed  = 1'b0;
        dPlusPin  = 1'b1;
        dMinusPin = 1'b0;
    end

    // Line state 0 is J, 1 is K and 2 is a single-ended zero; the encoding follows the speed.
    task automatic hold(input logic [1:0] st, input int n);
        @(posedge mclk);
        dPlusPin  <= (st != 2'd2) & ((st == 2'd0) ^ lowSpeed);
        dMinusPin <= (st != 2'd2) & ((st == 2'd1) ^ lowSpeed);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pulse(input logic stall, input logic sof, input logic tok, input logic [7:0] stat);
        @(posedge mclk);
        linkEvt.stallSent   <= stall;
        linkEvt.sofReceived <= sof;
        linkEvt.tokenDone   <= tok;
        linkEvt.tokenStatus <= stat;
        @(posedge mclk);
        linkEvt.stallSent   <= 1'b0;
        linkEvt.sofReceived <= 1'b0;
        linkEvt.tokenDone   <= 1'b0;
    endtask

    task automatic setErr(input logic [7:0] e);
        @(posedge mclk);
        linkEvt.errorStatus <= e;
    endtask

    task automatic setSpeed(input logic v);
        @(posedge mclk);
        lowSpeed <= v;
    endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic                   mclk   = 1'b0;
    logic                   arst_n;
    logic                   hsel;
    logic                   hwrite;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [31:0]            haddr;
    logic [31:0]            hwdata;
    logic                   hreadyout, hresp, vbusPwm, lowSpeed, dPlusPin, dMinusPin;
    logic [31:0]            hrdata, rd;
    uds_pkg::uds_link_evt_t linkEvt;
    int                     errCount = 0;
    int                     compares = 0;
    int                     cycles   = 0;
    localparam logic [7:0]  F = uds_pkg::OFS_FLAGS;

    always #5 mclk = ~mclk;

    // A short idle time keeps the run brief; the figure is not otherwise special.
    uds_status_top #(.IDLE_CYCLES(20), .FIFO_DEPTH(4)) uut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .linkEvt(linkEvt), .lowSpeed(lowSpeed),
        .dPlusPin(dPlusPin), .dMinusPin(dMinusPin), .vbusPwm(vbusPwm));
    uds_host_model host (.mclk(mclk), .linkEvt(linkEvt), .lowSpeed(lowSpeed), .dPlusPin(dPlusPin),
        .dMinusPin(dMinusPin));

    task automatic stop_test();
        if (errCount == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errCount++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hsize  <= 3'h2;
        haddr  <= {24'h00_0000, ofs};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    // Returning to J and writing ones to clear every flag but the read-only error summary keeps each line scenario independent of the last.
    task automatic settle();
        host.hold(2'd0, 40);
        bus(1'b1, F, 32'hFFFF_FFFF);
    endtask

    task automatic t_regs();
        host.hold(2'd0, 40);
        rdchk(F, 32'h0000_0010);
        bus(1'b1, F, 32'hFFFF_FFFF);
        rdchk(F, 32'h0000_0000);
        rdchk(uds_pkg::OFS_DESC_BASE, 32'h0000_0000);
        bus(1'b1, uds_pkg::OFS_DESC_BASE, 32'hFFFF_FFFF);
        rdchk(uds_pkg::OFS_DESC_BASE, 32'h0000_00FF);
        rdchk(uds_pkg::OFS_PWM_CTRL, 32'h0000_0000);
        rdchk(8'h40, 32'h0000_0000);
        chk({31'h0000_0000, vbusPwm}, 32'h0000_0000);
    endtask

    task automatic t_events();
        host.pulse(1'b1, 1'b1, 1'b0, 8'h00);
        rdchk(F, 32'h0000_0084);
        bus(1'b1, F, 32'h0000_0004);
        rdchk(F, 32'h0000_0080);
        bus(1'b1, F, 32'h0000_0000);
        rdchk(F, 32'h0000_0080);
        bus(1'b1, F, 32'h0000_0080);
        rdchk(F, 32'h0000_0000);
    endtask

    task automatic t_error();
        bus(1'b1, uds_pkg::OFS_ERR_ENABLE, 32'h0000_0001);
        host.setErr(8'h02);
        repeat (3) @(posedge mclk);
        rdchk(F, 32'h0000_0000);
        host.setErr(8'h01);
        repeat (3) @(posedge mclk);
        rdchk(F, 32'h0000_0002);
        bus(1'b1, F, 32'h0000_0002);
        rdchk(F, 32'h0000_0002);
        host.setErr(8'h00);
        repeat (3) @(posedge mclk);
        rdchk(F, 32'h0000_0000);
    endtask

    task automatic t_token();
        host.pulse(1'b0, 1'b0, 1'b1, 8'h11);
        host.pulse(1'b0, 1'b0, 1'b1, 8'h22);
        rdchk(uds_pkg::OFS_XFER_STAT, 32'h0000_0011);
        rdchk(F, 32'h0000_0008);
        bus(1'b1, F, 32'h0000_0008);
        rdchk(uds_pkg::OFS_XFER_STAT, 32'h0000_0022);
        rdchk(F, 32'h0000_0008);
        bus(1'b1, F, 32'h0000_0008);
        rdchk(F, 32'h0000_0000);
    endtask

    task automatic t_line();
        host.hold(2'd1, 240);
        rdchk(F, 32'h0000_0000);
        host.hold(2'd1, 20);
        rdchk(F, 32'h0000_0020);
        settle();
        host.setSpeed(1'b1);
        settle();
        host.hold(2'd1, 260);
        rdchk(F, 32'h0000_0020);
        host.setSpeed(1'b0);
        settle();
        host.hold(2'd2, 260);
        rdchk(F, 32'h0000_0001);
        bus(1'b1, F, 32'h0000_0001);
        host.hold(2'd2, 260);
        rdchk(F, 32'h0000_0000);
        settle();
    endtask

    task automatic pwmcnt(input logic [31:0] ctl, input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0000_0000;
        bus(1'b1, uds_pkg::OFS_PWM_CTRL, ctl);
        repeat (3) @(posedge mclk);
        repeat (8) begin
            @(posedge mclk);
            if (vbusPwm === 1'b1) n = n + 32'h0000_0001;
        end
        chk(n, exp);
    endtask

    // Period 3 and duty 1 give one active cycle in every four.
    task automatic t_pwm();
        bus(1'b1, uds_pkg::OFS_PWM_TIMING, 32'h0000_0103);
        pwmcnt(32'h0000_0200, 32'h0000_0008);
        pwmcnt(32'h0000_0000, 32'h0000_0000);
        pwmcnt(32'h0000_8000, 32'h0000_0008);
        pwmcnt(32'h0000_8100, 32'h0000_0002);
        pwmcnt(32'h0000_8300, 32'h0000_0006);
        rdchk(uds_pkg::OFS_PWM_CTRL, 32'h0000_8300);
    endtask

    initial begin
        arst_n = 1'b0;
        hsel   = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize  = 3'h2;
        haddr  = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_events();
        t_error();
        t_token();
        t_line();
        t_pwm();
        stop_test();
    end
endmodule
